// >>> include/ers_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the receive status bank.
 Assumes it is included by bare name from the bank module.
*/
`ifndef ERS_DEFS_SVH
`define ERS_DEFS_SVH

// Register indexes; byte address is four times the index
`define ERS_IDX_MF_ALIGN 6'h14
`define ERS_IDX_MSB_PHASE 6'h15
`define ERS_IDX_LSB_PHASE 6'h16
`define ERS_IDX_JA 6'h17
`define ERS_IDX_LINE 6'h18
`define ERS_IDX_IRQ_STAT 6'h1c
`define ERS_IDX_IRQ_MASK 6'h1d

// Upper phase word fields
`define ERS_SLIP_TOG_BIT 7
`define ERS_SLIP_DIR_BIT 6
`define ERS_AUX_BIT 5
`define ERS_TWO_BAD_BIT 4

// Dejitter status word fields
`define ERS_JA_SLOW_BIT 7
`define ERS_JA_FAST_BIT 6
`define ERS_JA_EMPTY_BIT 5
`define ERS_JA_FOUR_BIT 4
`define ERS_JA_HALF_BIT 3
`define ERS_JA_NEAR_BIT 2
`define ERS_JA_FULL_BIT 1

// Line status word fields
`define ERS_LINE_LONG_BIT 7
`define ERS_LINE_MED_BIT 6
`define ERS_LINE_SHORT_BIT 5
`define ERS_LINE_LOS_BIT 4

// Interrupt status and mask fields
`define ERS_IRQ_SLIP_BIT 0
`define ERS_IRQ_AUX_BIT 1
`define ERS_IRQ_TWO_BAD_BIT 2
`define ERS_IRQ_LOS_BIT 3
`define ERS_IRQ_MF_BIT 4
`define ERS_IRQ_W 5

// Reset values
`define ERS_RST_BYTE 8'h00
`define ERS_RST_PHASE 12'h000
`define ERS_RST_IRQ 5'h00

// Timing
`define ERS_CLK_PERIOD_NS 50
`define ERS_LOS_TIME_US 1000
`define ERS_LOS_CYCLES (((`ERS_LOS_TIME_US * 1000) + `ERS_CLK_PERIOD_NS - 1) / `ERS_CLK_PERIOD_NS)
`define ERS_AUX_WINDOW_BITS 512
`define ERS_AUX_ERR_MAX 1
`define ERS_JA_DEPTH 32
`define ERS_JA_MARGIN 4

`endif

// >>> include/ers_pkg.sv
/*
 Types shared by the receive status bank and its surroundings.
 Assumes ers_defs.svh sits on the include path.
*/
`default_nettype none
package ers_pkg;

   // Time slot 16 byte of frame zero, first received bit at the top
   typedef struct packed {
      logic [3:0] mf_align_bits;
      logic spare_bit_one;
      logic remote_mf_loss;
      logic [1:0] spare_bits_two_three;
   } ers_mf_byte_t;

   // Attenuation class reported by the line equalizer
   typedef struct packed {
      logic long_line_flag;
      logic medium_line_flag;
      logic short_line_flag;
   } ers_line_class_t;

   // Phase measurement sequence
   typedef enum logic [0:0] {
      PH_IDLE,
      PH_COUNT
   } ers_phase_state_t;

endpackage
`default_nettype wire

// >>> src/ers_status_bank.sv
/*
 Receive status words of an E1 framer, read over APB, with a sticky interrupt bank.
 Assumes all event inputs come from logic on clk; only the line amplitude-low
 indication arrives from the analog front end and is synchronised here.
*/
//
// Contract
// - TS16 frame zero bits 1-4 to top nibble
// - Bit five shown as first spare bit
// - Bit six shown as remote multiframe flag
// - Bits seven, eight shown as spare bits two/three
// - Slip toggle inverts on every controlled slip
// - Slip direction updated on each slip
// - Alternating pattern flag after 512 bits, tolerant
// - Flag when last two alignment words bad
// - 12-bit eighth-bit phase count, top nibble shown
// - Low phase byte in separate word
// - Slow flag while dejittered clock lengthened
// - Fast flag while dejittered clock shortened
// - FIFO empty bit5, FIFO full bit1
// - Four-filled and half-full FIFO flags
// - Long, medium, short line class flags
// - Loss of signal after 1 ms low amplitude
`timescale 1ns/100ps
`default_nettype none
`include "ers_defs.svh"

module ers_status_bank
   import ers_pkg::*;
#(
   parameter int JA_DEPTH = `ERS_JA_DEPTH,
   parameter int LOS_CYCLES = `ERS_LOS_CYCLES
) (
   input wire logic clk, // 20 MHz system clock
   input wire logic rst_b, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   output logic irq, // Level interrupt
   input wire logic ts16_f0_valid, // TS16 frame zero byte strobe
   input wire ers_mf_byte_t ts16_f0_byte, // TS16 frame zero byte
   input wire logic slip_event, // Controlled frame slip pulse
   input wire logic slip_repeat, // Slip repeated a frame
   input wire logic rx_bit_valid, // Received line bit strobe
   input wire logic rx_bit, // Received line bit
   input wire logic fas_check_valid, // Alignment word checked
   input wire logic fas_check_error, // Checked alignment word bad
   input wire logic backplane_frame_pulse, // Backplane frame start
   input wire logic rx_frame_pulse, // Receive frame start
   input wire logic eighth_bit_tick, // One eighth of a bit time
   input wire logic dejitter_slow_in, // Clock trim lengthened
   input wire logic dejitter_fast_in, // Clock trim shortened
   input wire logic [$clog2(JA_DEPTH+1)-1:0] dejitter_fifo_level, // Filled locations
   input wire ers_line_class_t line_class, // Equalizer class
   input wire logic line_amp_low_pin // Amplitude 20 dB low, async
);

   localparam int LVL_W = $clog2(JA_DEPTH + 1);
   localparam int LOS_W = $clog2(LOS_CYCLES + 1);

   // Elaboration check
   if (JA_DEPTH < 2 * `ERS_JA_MARGIN || LOS_CYCLES < 1) begin : g_bad_param
      $error("ers_status_bank: JA_DEPTH below 8 or LOS_CYCLES below 1");
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // ******************************************************
   // Helpers
   // ******************************************************

   // Word decode at an aligned index
   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      hit = (a[7:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   // ******************************************************
   // State
   // ******************************************************
   ers_mf_byte_t mf_align;
   logic slip_toggle;
   logic slip_direction;
   logic alt_pattern_detect;
   logic two_bad_align_words;
   logic last_fas_error;
   logic [11:0] rx_phase_count;
   logic [11:0] phase_run;
   ers_phase_state_t phase_state;
   logic [7:0] ja_status;
   ers_line_class_t line_flags;
   logic line_signal_lost;
   logic [9:0] aux_bits;
   logic [9:0] aux_miss;
   logic amp_meta;
   logic amp_low;
   logic [LOS_W-1:0] los_cnt;
   logic [`ERS_IRQ_W-1:0] irq_status;
   logic [`ERS_IRQ_W-1:0] irq_mask;

   // ******************************************************
   // Multiframe alignment byte and slips
   // ******************************************************

   // Whole byte kept as received so bit order matches the line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mf_align <= ers_mf_byte_t'(`ERS_RST_BYTE);
      end else if (ts16_f0_valid) begin
         mf_align <= ts16_f0_byte;
      end
   end

   // Toggle rather than sticky so software never has to clear it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slip_toggle <= 1'b0;
         slip_direction <= 1'b0;
      end else if (slip_event) begin
         slip_toggle <= ~slip_toggle;
         slip_direction <= slip_repeat;
      end
   end

   // ******************************************************
   // Alternating pattern detector
   // ******************************************************
   logic aux_exp;
   logic [9:0] next_aux_miss;
   logic aux_window_end;
   logic aux_ok;

   // Mismatches against one phase; the other phase is the complement
   always_comb begin
      aux_exp = aux_bits[0];
      next_aux_miss = aux_miss + {9'h000, rx_bit != aux_exp};
      aux_window_end = rx_bit_valid && (aux_bits == 10'(`ERS_AUX_WINDOW_BITS - 1));
      aux_ok = (next_aux_miss <= 10'(`ERS_AUX_ERR_MAX)) ||
               (next_aux_miss >= 10'(`ERS_AUX_WINDOW_BITS - `ERS_AUX_ERR_MAX));
   end

   // Decided per 512-bit window; one error per window covers 1e-3
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aux_bits <= 10'h000;
         aux_miss <= 10'h000;
         alt_pattern_detect <= 1'b0;
      end else if (aux_window_end) begin
         aux_bits <= 10'h000;
         aux_miss <= 10'h000;
         alt_pattern_detect <= aux_ok;
      end else if (rx_bit_valid) begin
         aux_bits <= aux_bits + 10'h001;
         aux_miss <= next_aux_miss;
      end
   end

   // ******************************************************
   // Consecutive alignment errors
   // ******************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_fas_error <= 1'b0;
         two_bad_align_words <= 1'b0;
      end else if (fas_check_valid) begin
         last_fas_error <= fas_check_error;
         two_bad_align_words <= fas_check_error && last_fas_error;
      end
   end

   // ******************************************************
   // Phase measurement
   // ******************************************************

   // Resolution is one tick, so within an eighth of a bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_state <= PH_IDLE;
         phase_run <= `ERS_RST_PHASE;
         rx_phase_count <= `ERS_RST_PHASE;
      end else begin
         case (phase_state)
            PH_IDLE: begin
               if (backplane_frame_pulse && rx_frame_pulse) begin
                  rx_phase_count <= `ERS_RST_PHASE;
               end else if (backplane_frame_pulse) begin
                  phase_run <= `ERS_RST_PHASE;
                  phase_state <= PH_COUNT;
               end
            end
            PH_COUNT: begin
               if (rx_frame_pulse) begin
                  rx_phase_count <= phase_run;
                  phase_state <= PH_IDLE;
               end else if (backplane_frame_pulse) begin
                  phase_run <= `ERS_RST_PHASE;
               end else if (eighth_bit_tick) begin
                  phase_run <= phase_run + 12'h001;
               end
            end
            default: begin
               phase_state <= PH_IDLE;
            end
         endcase
      end
   end

   // ******************************************************
   // Dejitter FIFO flags
   // ******************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ja_status <= `ERS_RST_BYTE;
      end else begin
         ja_status <= `ERS_RST_BYTE;
         ja_status[`ERS_JA_SLOW_BIT] <= dejitter_slow_in;
         ja_status[`ERS_JA_FAST_BIT] <= dejitter_fast_in;
         ja_status[`ERS_JA_EMPTY_BIT] <= dejitter_fifo_level == '0;
         ja_status[`ERS_JA_FOUR_BIT] <=
            dejitter_fifo_level >= LVL_W'(`ERS_JA_MARGIN);
         ja_status[`ERS_JA_HALF_BIT] <= dejitter_fifo_level >= LVL_W'(JA_DEPTH / 2);
         ja_status[`ERS_JA_NEAR_BIT] <=
            dejitter_fifo_level >= LVL_W'(JA_DEPTH - `ERS_JA_MARGIN);
         ja_status[`ERS_JA_FULL_BIT] <= dejitter_fifo_level == LVL_W'(JA_DEPTH);
      end
   end

   // ******************************************************
   // Line class and loss of signal
   // ******************************************************

   // Front-end level crosses domains; only amp_low is read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         amp_meta <= 1'b0;
         amp_low <= 1'b0;
      end else begin
         amp_meta <= line_amp_low_pin;
         amp_low <= amp_meta;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_flags <= '0;
      end else begin
         line_flags <= line_class;
      end
   end

   // Saturating count; any return of amplitude restarts the wait
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         los_cnt <= '0;
         line_signal_lost <= 1'b0;
      end else if (!amp_low) begin
         los_cnt <= '0;
         line_signal_lost <= 1'b0;
      end else if (los_cnt == LOS_W'(LOS_CYCLES - 1)) begin
         line_signal_lost <= 1'b1;
      end else begin
         los_cnt <= los_cnt + LOS_W'(1);
      end
   end

   // ******************************************************
   // Interrupt bank
   // ******************************************************
   logic [`ERS_IRQ_W-1:0] irq_events;
   logic irq_read;
   logic apb_access;

   assign apb_access = psel && penable && pready;
   assign irq_read = apb_access && !pwrite && hit(paddr, `ERS_IDX_IRQ_STAT);

   // Rising edges of the pattern, two-bad and loss flags, one cycle early from their causes; slip and byte strobes set directly
   always_comb begin
      irq_events = '0;
      irq_events[`ERS_IRQ_SLIP_BIT] = slip_event;
      irq_events[`ERS_IRQ_AUX_BIT] = aux_window_end && aux_ok && !alt_pattern_detect;
      irq_events[`ERS_IRQ_TWO_BAD_BIT] = fas_check_valid && fas_check_error &&
                                         last_fas_error && !two_bad_align_words;
      irq_events[`ERS_IRQ_LOS_BIT] = amp_low && !line_signal_lost &&
                                     (los_cnt == LOS_W'(LOS_CYCLES - 1));
      irq_events[`ERS_IRQ_MF_BIT] = ts16_f0_valid;
   end

   // Set wins over the read-clear; only bits already handed out are cleared
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_status <= `ERS_RST_IRQ;
      end else if (irq_read) begin
         irq_status <= (irq_status & ~prdata[`ERS_IRQ_W-1:0]) | irq_events;
      end else begin
         irq_status <= irq_status | irq_events;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask <= `ERS_RST_IRQ;
      end else if (apb_access && pwrite && hit(paddr, `ERS_IDX_IRQ_MASK)) begin
         irq_mask <= pwdata[`ERS_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ******************************************************
   // APB slave
   // ******************************************************
   logic [7:0] msb_word;
   logic [7:0] line_word;
   logic [31:0] rd_word;
   logic mapped;

   always_comb begin
      msb_word = {4'h0, rx_phase_count[11:8]};
      msb_word[`ERS_SLIP_TOG_BIT] = slip_toggle;
      msb_word[`ERS_SLIP_DIR_BIT] = slip_direction;
      msb_word[`ERS_AUX_BIT] = alt_pattern_detect;
      msb_word[`ERS_TWO_BAD_BIT] = two_bad_align_words;
      line_word = `ERS_RST_BYTE;
      line_word[`ERS_LINE_LONG_BIT] = line_flags.long_line_flag;
      line_word[`ERS_LINE_MED_BIT] = line_flags.medium_line_flag;
      line_word[`ERS_LINE_SHORT_BIT] = line_flags.short_line_flag;
      line_word[`ERS_LINE_LOS_BIT] = line_signal_lost;
      mapped = 1'b1;
      rd_word = 32'h0000_0000;
      if (hit(paddr, `ERS_IDX_MF_ALIGN)) begin
         rd_word[7:0] = mf_align;
      end else if (hit(paddr, `ERS_IDX_MSB_PHASE)) begin
         rd_word[7:0] = msb_word;
      end else if (hit(paddr, `ERS_IDX_LSB_PHASE)) begin
         rd_word[7:0] = rx_phase_count[7:0];
      end else if (hit(paddr, `ERS_IDX_JA)) begin
         rd_word[7:0] = ja_status;
      end else if (hit(paddr, `ERS_IDX_LINE)) begin
         rd_word[7:0] = line_word;
      end else if (hit(paddr, `ERS_IDX_IRQ_STAT)) begin
         rd_word[`ERS_IRQ_W-1:0] = irq_status;
      end else if (hit(paddr, `ERS_IDX_IRQ_MASK)) begin
         rd_word[`ERS_IRQ_W-1:0] = irq_mask;
      end else begin
         mapped = 1'b0;
      end
   end

   // Answer prepared in setup so every output leaves a flop; one access cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
         pready <= 1'b1;
         pslverr <= !mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ******************************************************
   // Checks
   // ******************************************************
   chk_mf_capture: assert property (ts16_f0_valid |=> mf_align == $past(ts16_f0_byte))
      else $error("multiframe byte not captured");
   chk_mf_hold: assert property (!ts16_f0_valid |=> $stable(mf_align))
      else $error("multiframe byte changed without a strobe");
   chk_slip_toggle: assert property (slip_event |=> slip_toggle != $past(slip_toggle))
      else $error("slip toggle did not invert");
   chk_slip_quiet: assert property (!slip_event |=> $stable(slip_toggle))
      else $error("slip toggle moved without a slip");
   chk_slip_dir: assert property (slip_event |=> slip_direction == $past(slip_repeat))
      else $error("slip direction not updated");
   chk_aux_window: assert property ($rose(alt_pattern_detect) |-> $past(aux_bits) == 10'h1ff)
      else $error("pattern flag rose off a window end");
   chk_two_bad: assert property (fas_check_valid && fas_check_error && last_fas_error
                                 |=> two_bad_align_words)
      else $error("two bad alignment words not flagged");
   chk_two_good: assert property (fas_check_valid && !fas_check_error
                                  |=> !two_bad_align_words ##1 !two_bad_align_words)
      else $error("bad alignment flag held after a good word");
   chk_phase_latch: assert property (phase_state == PH_COUNT && rx_frame_pulse
                                     |=> rx_phase_count == $past(phase_run))
      else $error("phase count not latched");
   chk_fifo_empty: assert property (1'b1 |=> ja_status[`ERS_JA_EMPTY_BIT] ==
                                    ($past(dejitter_fifo_level) == '0))
      else $error("empty flag wrong");
   chk_fifo_full: assert property (1'b1 |=> ja_status[`ERS_JA_FULL_BIT] ==
                                   ($past(dejitter_fifo_level) == LVL_W'(JA_DEPTH)))
      else $error("full flag wrong");
   chk_los_timing: assert property ($rose(line_signal_lost) |->
                                    $past(los_cnt) == LOS_W'(LOS_CYCLES - 1))
      else $error("loss of signal raised early");
   chk_ja_unused: assert property (psel && !penable && !pwrite && hit(paddr, `ERS_IDX_JA)
                                   |=> prdata[0] == 1'b0 && prdata[31:8] == 24'h000000)
      else $error("unused dejitter bits not zero");
   chk_irq_level: assert property (irq == $past(|(irq_status & irq_mask)))
      else $error("interrupt level mismatch");

endmodule // ers_status_bank
`default_nettype wire

// >>> testbench/ers_line_model.sv
/*
 Far-end E1 line model: received bits with a strobe, alternating or random.
 Assumes the bank samples rx_bit only while rx_bit_valid is high.
*/
`timescale 1ns/100ps
`default_nettype none

module ers_line_model (
   input wire logic clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic alt_mode, // Send alternating pattern
   output logic rx_bit_valid, // Bit strobe
   output logic rx_bit // Line bit
);
   int seed = 5;
   int nbits;
   logic phase;

   // One bit every other cycle; junk between strobes so nothing leans on a stale bit
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_bit_valid <= 1'b0;
         rx_bit <= 1'b0;
         phase <= 1'b0;
         nbits <= 0;
      end else begin
         rx_bit_valid <= ~rx_bit_valid;
         if (rx_bit_valid) begin
            rx_bit <= ~rx_bit;
         end else begin
            nbits <= nbits + 1;
            phase <= ~phase;
            // One flipped bit per 1000 keeps the error rate at the tolerated limit
            if (alt_mode) rx_bit <= phase ^ (nbits % 1000 == 500);
            else rx_bit <= 1'($random(seed));
         end
      end
   end
endmodule // ers_line_model

`default_nettype wire

// >>> testbench/tb_top.sv
/*
 Self-checking bench of the receive status bank: APB master, event drivers,
 line model and integer expectations.
 Assumes a zero-wait APB slave and a shortened loss-of-signal count.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import ers_pkg::*;
;
   localparam int LOSC = 8;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, irq, perr, rbv, rb, tick = 1'b0;
   logic [3:0] pl = 4'h0;
   ers_mf_byte_t ts_byte = 8'h00;
   logic slip_rep = 1'b0, fas_err = 1'b0, slow = 1'b0, fast = 1'b0, amp_low = 1'b0, alt = 1'b0;
   logic [5:0] lvl = 6'h00;
   logic rfp = 1'b0;
   ers_line_class_t lcls = 3'h0;
   int errors = 0, check_count = 0, seed = 5, tog = 0, dir = 0, aux = 0, bad = 0, ph = 0;
   int q[$];

   ers_status_bank #(.LOS_CYCLES(LOSC)) DUT (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .ts16_f0_valid(pl[0]), .ts16_f0_byte(ts_byte), .slip_event(pl[1]),
      .slip_repeat(slip_rep), .rx_bit_valid(rbv), .rx_bit(rb), .fas_check_valid(pl[2]),
      .fas_check_error(fas_err), .backplane_frame_pulse(pl[3]), .rx_frame_pulse(tick ? 1'b0 : pl[3] ? 1'b0 : rfp),
      .eighth_bit_tick(tick), .dejitter_slow_in(slow), .dejitter_fast_in(fast),
      .dejitter_fifo_level(lvl), .line_class(lcls), .line_amp_low_pin(amp_low));

   ers_line_model line (.clk(clk), .rst_b(rst_b), .alt_mode(alt), .rx_bit_valid(rbv), .rx_bit(rb));

   // 20 MHz clock
   always #25 clk = ~clk;

   // ************************
   // Shared tasks
   // ************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits on pready rather than trusting the zero-wait figure
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
      chk(32'(perr), 32'(!(a inside {8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h70, 8'h74})));
   endtask

   task automatic pulse(input int i);
      pl[i] <= 1'b1;
      @(posedge clk);
      pl[i] <= 1'b0;
      @(posedge clk);
   endtask

   function automatic logic [31:0] msw();
      return 32'({tog[0], dir[0], aux[0], bad[0], ph[11:8]});
   endfunction

   task automatic tend(input string s);
      $display("test %0s done", s);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ************************
   // Scenarios
   // ************************
   initial begin
      logic [7:0] b;
      logic [4:0] e;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) rd(8'h50 + 8'(4 * i), (i == 3) ? 32'h20 : 32'h0);
      rd(8'h64, 32'h0);
      tend("reset");
      repeat (3) begin
         b = 8'($random(seed));
         q.push_back(b);
         ts_byte <= b;
         pulse(0);
      end
      rd(8'h50, 32'(q[$]));
      apb(1'b1, 8'h50, 32'hffff_ffff);
      rd(8'h50, 32'(q[$]));
      tend("ts16");
      for (int i = 0; i < 3; i++) begin
         slip_rep <= i[0];
         pulse(1);
         tog ^= 1;
         dir = i & 1;
         rd(8'h54, msw());
      end
      e = 5'b01011;
      for (int i = 0; i < 5; i++) begin
         fas_err <= e[i];
         pulse(2);
         bad = (i > 0) && e[i] && e[i-1];
         rd(8'h54, msw());
      end
      tend("slip and alignment");
      // Frame pulse, then ph ticks, then the receive pulse with no tick beside it
      ph = 1024 + ($random(seed) & 1023);
      pulse(3);
      tick <= 1'b1;
      repeat (ph) @(posedge clk);
      tick <= 1'b0;
      rfp <= 1'b1;
      @(posedge clk);
      rfp <= 1'b0;
      @(posedge clk);
      rd(8'h54, msw());
      rd(8'h58, 32'(ph[7:0]));
      tend("phase");
      for (int i = 0; i <= 32; i++) begin
         lvl <= 6'(i);
         slow <= 1'($random(seed));
         fast <= 1'($random(seed));
         repeat (2) @(posedge clk);
         rd(8'h5c, 32'({slow, fast, i == 0, i >= 4, i >= 16, i >= 28, i == 32, 1'b0}));
      end
      for (int i = 0; i < 3; i++) begin
         lcls <= 3'($random(seed));
         amp_low <= (i == 1);
         repeat (LOSC + 6) @(posedge clk);
         rd(8'h60, 32'({lcls, i == 1, 4'h0}));
      end
      tend("dejitter and line");
      for (int i = 1; i >= 0; i--) begin
         alt <= i[0];
         repeat (2300) @(posedge clk);
         aux = i;
         rd(8'h54, msw());
      end
      tend("pattern");
      chk(32'(irq), 32'h0);
      apb(1'b1, 8'h74, 32'h1f);
      rd(8'h74, 32'h1f);
      chk(32'(irq), 32'h1);
      rd(8'h70, 32'h1f);
      @(posedge clk);
      chk(32'(irq), 32'h0);
      rd(8'h70, 32'h0);
      apb(1'b1, 8'h74, 32'h01);
      pulse(0);
      @(posedge clk);
      chk(32'(irq), 32'h0);
      pulse(1);
      @(posedge clk);
      chk(32'(irq), 32'h1);
      rd(8'h70, 32'h11);
      tend("interrupt");
      test_done;
   end

   // Whole run is about 6000 to 7000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      test_done;
   end
endmodule // tb_top

`default_nettype wire
